//--- verilog/fbp_pkg.sv
// Shared constants and types for the flash block guard and event reporting
package fbp_pkg;
    localparam logic [7:0]  ADDR_GUARD      = 8'hFA;
    localparam logic [7:0]  ADDR_IRQ        = 8'hFB;
    localparam logic [7:0]  GUARD_RESET     = 8'hFF;
    localparam logic [7:0]  GUARD_ALL       = 8'hFF;
    localparam logic [7:0]  IRQ_RESET       = 8'h00;
    localparam logic [7:0]  RDATA_UNMAPPED  = 8'h00;
    // Bit layout of the event/interrupt register
    localparam int          IRQ_DONE_IE_BIT = 7;
    localparam int          IRQ_ERR_IE_BIT  = 6;
    localparam int          IRQ_DONE_BIT    = 5;
    localparam int          IRQ_RSVD_BIT    = 4;
    localparam int          ERR_TMO_BIT     = 3;
    localparam int          ERR_WR_BIT      = 2;
    localparam int          ERR_PE_BIT      = 1;
    localparam int          ERR_ME_BIT      = 0;
    localparam int          ERR_W           = 4;
    localparam logic [3:0]  ERR_NONE        = 4'h0;
    // Flash geometry: 128 KB in eight 16 KB blocks
    localparam int          FADDR_W         = 17;
    localparam int          BLK_LSB         = 14;
    localparam int          BLK_MSB         = 16;
    localparam int          SMALL_BLOCKS    = 4;
    localparam logic [7:0]  SMALL_MASK      = 8'h0F;
    // Row program limit, counted in flash controller clocks
    localparam int          ROW_LIMIT_FCLKS = 2432;
    localparam int          TMR_W           = 12;
    localparam logic [11:0] ROW_LIMIT_LAST  = 12'(ROW_LIMIT_FCLKS - 1);
    localparam logic [11:0] TMR_ZERO        = 12'h000;
    localparam logic [11:0] TMR_ONE         = 12'h001;

    typedef enum logic [1:0] {
        OP_WRITE      = 2'b00,
        OP_PAGE_ERASE = 2'b01,
        OP_MASS_ERASE = 2'b10,
        OP_ROW_PROG   = 2'b11
    } fbp_op_t;

    typedef enum logic {
        TMR_IDLE = 1'b0,
        TMR_RUN  = 1'b1
    } fbp_tmr_state_t;
endpackage

//--- verilog/fbp_tmr_if.sv
// Link between the guard logic and the row program watchdog
`timescale 1ns/1ps
interface fbp_tmr_if;
    logic start;
    logic stop;
    logic tick;
    logic expired;

    modport ctrl (output start, output stop, output tick, input expired);
    modport tmr  (input start, input stop, input tick, output expired);
endinterface

//--- verilog/fbp_rp_timer.sv
// Row program watchdog counting flash controller clock ticks
`timescale 1ns/1ps
module fbp_rp_timer
    import fbp_pkg::*;
(
    input wire logic    sys_clk,
    input wire logic    rst_n,
    fbp_tmr_if.tmr      tif
);
    fbp_tmr_state_t     state;
    fbp_tmr_state_t     next_state;
    logic [TMR_W-1:0]   count;
    logic [TMR_W-1:0]   next_count;
    logic               expired;
    logic               next_expired;

    assign tif.expired = expired;

    always_comb begin
        next_state   = state;
        next_count   = count;
        next_expired = 1'b0;
        unique case (state)
            TMR_IDLE: begin
                if (tif.start) begin
                    next_state = TMR_RUN;
                    next_count = TMR_ZERO;
                end
            end
            TMR_RUN: begin
                if (tif.stop) begin
                    next_state = TMR_IDLE;
                end else if (tif.tick) begin
                    if (count == ROW_LIMIT_LAST) begin
                        next_state   = TMR_IDLE;
                        next_expired = 1'b1;
                    end else begin
                        next_count = count + TMR_ONE;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state   <= TMR_IDLE;
            count   <= TMR_ZERO;
            expired <= 1'b0;
        end else begin
            state   <= next_state;
            count   <= next_count;
            expired <= next_expired;
        end
    end

    a_tmo_exact_count: assert property (@(posedge sys_clk) disable iff (!rst_n)
        expired |-> $past(state) == TMR_RUN && $past(count) == ROW_LIMIT_LAST && $past(tif.tick))
        else $error("watchdog expired at wrong count");
endmodule

//--- verilog/fbp_guard.sv
// Flash block write/erase guard with key lock and event interrupt register
// How it works
// - Eight guard bits, one per 16 KB block; a set bit blocks write and erase.
// - Every guard bit reads one after reset, all blocks protected.
// - Information page accesses other than mass erase are never checked against the guard bits.
// - Mass erase is refused while any guard bit of an existing block is one.
// - Guard register stores write data only while unlocked; a locked write cannot clear a bit.
// - A guard write while locked forces all guard bits to one.
// - Guard bit n covers the 16 KB block starting at n times 0x4000.
// - On the 64 KB variant guard bits seven to four are unused.
// - Two event sources: successful completion and any error.
// - Each event source has its own enable bit.
// - Row program exceeding 2432 flash clocks is aborted and flags a timeout.
// - A write into a guarded block is refused and flags a write violation.
// - A page erase in a guarded block is refused and flags a violation.
// - A refused mass erase flags a mass erase violation.
// - With error enable set, any error flag requests an interrupt.
// - Reading the event register clears done and error flags, keeps enables.
// - Done interrupt stays low while its enable is zero.
// - Error enable one allows error interrupts; zero suppresses them.
// - Done flag sets when erase or row program completes successfully.
`timescale 1ns/1ps
module fbp_guard
    import fbp_pkg::*;
(
    input  wire logic               sys_clk,
    input  wire logic               rst_n,
    input  wire logic [7:0]         reg_addr,
    input  wire logic [7:0]         reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    output logic [7:0]              reg_rdata,
    input  wire logic               key_unlock,
    input  wire logic               key_relock,
    input  wire logic               small_dev,
    input  wire logic               op_req,
    input  wire logic [1:0]         op_kind,
    input  wire logic [FADDR_W-1:0] op_addr,
    input  wire logic               op_info,
    input  wire logic               op_done,
    input  wire logic               fctl_tick,
    output logic                    op_grant,
    output logic                    op_deny,
    output logic                    rp_abort,
    output logic                    locked,
    output logic                    irq_err,
    output logic                    irq_done
);
    fbp_tmr_if tif ();

    fbp_rp_timer u_rp_timer (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .tif     (tif)
    );

    logic [7:0]         guard;
    logic [7:0]         next_guard;
    logic               next_locked;
    logic               done_ie;
    logic               next_done_ie;
    logic               err_ie;
    logic               next_err_ie;
    logic               done_flag;
    logic               next_done_flag;
    logic [ERR_W-1:0]   err;
    logic [ERR_W-1:0]   next_err;
    logic [7:0]         next_rdata;
    logic               next_grant;
    logic               next_deny;
    logic               next_abort;
    logic               next_irq_err;
    logic               next_irq_done;

    logic [7:0]         guard_eff;
    logic [2:0]         blk_idx;
    logic               blk_guarded;
    logic               wr_guard;
    logic               wr_irq;
    logic               rd_irq;
    logic [ERR_W-1:0]   err_set;
    fbp_op_t            kind;

    assign kind     = fbp_op_t'(op_kind);
    assign wr_guard = reg_wr && reg_addr == ADDR_GUARD;
    assign wr_irq   = reg_wr && reg_addr == ADDR_IRQ;
    assign rd_irq   = reg_rd && reg_addr == ADDR_IRQ;

    // Small variant: missing upper blocks must not block mass erase
    assign guard_eff   = small_dev ? (guard & SMALL_MASK) : guard;
    assign blk_idx     = op_addr[BLK_MSB:BLK_LSB];
    assign blk_guarded = !op_info && guard_eff[blk_idx];

    // Lock state and guard register
    always_comb begin
        next_locked = locked;
        if (key_unlock) begin
            next_locked = 1'b0;
        end
        if (key_relock) begin
            next_locked = 1'b1;
        end
        next_guard = guard;
        if (wr_guard) begin
            if (locked) begin
                next_guard = GUARD_ALL;
            end else begin
                next_guard = reg_wdata;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            locked <= 1'b1;
            guard  <= GUARD_RESET;
        end else begin
            locked <= next_locked;
            guard  <= next_guard;
        end
    end

    // Operation checks against the guard bits
    always_comb begin
        next_grant = 1'b0;
        next_deny  = 1'b0;
        err_set    = ERR_NONE;
        if (op_req) begin
            unique case (kind)
                OP_WRITE, OP_ROW_PROG: begin
                    if (blk_guarded) begin
                        next_deny          = 1'b1;
                        err_set[ERR_WR_BIT] = 1'b1;
                    end else begin
                        next_grant = 1'b1;
                    end
                end
                OP_PAGE_ERASE: begin
                    if (blk_guarded) begin
                        next_deny          = 1'b1;
                        err_set[ERR_PE_BIT] = 1'b1;
                    end else begin
                        next_grant = 1'b1;
                    end
                end
                OP_MASS_ERASE: begin
                    if (|guard_eff) begin
                        next_deny          = 1'b1;
                        err_set[ERR_ME_BIT] = 1'b1;
                    end else begin
                        next_grant = 1'b1;
                    end
                end
            endcase
        end
        if (tif.expired) begin
            err_set[ERR_TMO_BIT] = 1'b1;
        end
    end

    // Watchdog only runs for a granted row program
    assign tif.start = op_req && kind == OP_ROW_PROG && !blk_guarded;
    assign tif.stop  = op_done;
    assign tif.tick  = fctl_tick;

    // Event register; a new event wins over the read clear
    always_comb begin
        next_done_ie   = done_ie;
        next_err_ie    = err_ie;
        next_done_flag = done_flag;
        next_err       = err;
        if (wr_irq) begin
            next_done_ie = reg_wdata[IRQ_DONE_IE_BIT];
            next_err_ie  = reg_wdata[IRQ_ERR_IE_BIT];
        end
        if (rd_irq) begin
            next_done_flag = 1'b0;
            next_err       = ERR_NONE;
        end
        if (op_done) begin
            next_done_flag = 1'b1;
        end
        next_err   = next_err | err_set;
        next_abort = tif.expired;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            done_ie   <= IRQ_RESET[IRQ_DONE_IE_BIT];
            err_ie    <= IRQ_RESET[IRQ_ERR_IE_BIT];
            done_flag <= IRQ_RESET[IRQ_DONE_BIT];
            err       <= IRQ_RESET[ERR_W-1:0];
        end else begin
            done_ie   <= next_done_ie;
            err_ie    <= next_err_ie;
            done_flag <= next_done_flag;
            err       <= next_err;
        end
    end

    // Read mux and registered outputs
    always_comb begin
        next_rdata = RDATA_UNMAPPED;
        if (reg_rd) begin
            if (reg_addr == ADDR_GUARD) begin
                next_rdata = guard;
            end else if (reg_addr == ADDR_IRQ) begin
                next_rdata[IRQ_DONE_IE_BIT] = done_ie;
                next_rdata[IRQ_ERR_IE_BIT]  = err_ie;
                next_rdata[IRQ_DONE_BIT]    = done_flag;
                next_rdata[IRQ_RSVD_BIT]    = 1'b0;
                next_rdata[ERR_W-1:0]       = err;
            end
        end
        // Requests follow flags by one cycle so they come from flops
        next_irq_err  = err_ie && (|err);
        next_irq_done = done_ie && done_flag;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= RDATA_UNMAPPED;
            op_grant  <= 1'b0;
            op_deny   <= 1'b0;
            rp_abort  <= 1'b0;
            irq_err   <= 1'b0;
            irq_done  <= 1'b0;
        end else begin
            reg_rdata <= next_rdata;
            op_grant  <= next_grant;
            op_deny   <= next_deny;
            rp_abort  <= next_abort;
            irq_err   <= next_irq_err;
            irq_done  <= next_irq_done;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence s_locked_guard_write;
        reg_wr && reg_addr == ADDR_GUARD && locked;
    endsequence

    sequence s_unlocked_guard_write;
        reg_wr && reg_addr == ADDR_GUARD && !locked;
    endsequence

    sequence s_mass_try_guarded;
        op_req && kind == OP_MASS_ERASE && (|guard_eff);
    endsequence

    sequence s_irq_read_quiet;
        rd_irq && !op_done && !op_req && !tif.expired;
    endsequence

    sequence s_guarded_row_prog;
        op_req && kind == OP_ROW_PROG && blk_guarded;
    endsequence

    // Mass erase with no effective guard bit left set
    sequence s_mass_try_free;
        op_req && kind == OP_MASS_ERASE && !(|guard_eff);
    endsequence

    a_locked_forces_ones: assert property (
        s_locked_guard_write |=> guard == GUARD_ALL)
        else $error("locked guard write did not force all ones");

    a_unlocked_write_stores: assert property (
        s_unlocked_guard_write |=> guard == $past(reg_wdata))
        else $error("unlocked guard write not stored");

    a_mass_erase_refused: assert property (
        s_mass_try_guarded |=> op_deny && !op_grant && err[ERR_ME_BIT]
            ##1 (!op_deny || $past(op_req)))
        else $error("mass erase not refused while guarded");

    a_write_violation_flag: assert property (
        op_req && kind == OP_WRITE && blk_guarded |=> op_deny && err[ERR_WR_BIT])
        else $error("guarded write not flagged");

    a_page_erase_flag: assert property (
        op_req && kind == OP_PAGE_ERASE && blk_guarded |=> !op_grant && err[ERR_PE_BIT])
        else $error("guarded page erase not flagged");

    a_info_page_free: assert property (
        op_req && op_info && kind != OP_MASS_ERASE |=> op_grant && !op_deny)
        else $error("information page access refused");

    a_read_clears_flags: assert property (
        s_irq_read_quiet |=> !done_flag && err == ERR_NONE && $stable(done_ie) && $stable(err_ie))
        else $error("event register read did not clear flags");

    a_err_irq_follows: assert property (
        err_ie && (|err) && !rd_irq && !wr_irq |=> irq_err ##1 irq_err)
        else $error("error interrupt not raised");

    a_done_irq_gated: assert property (
        !done_ie |=> !irq_done)
        else $error("done interrupt raised while disabled");

    a_timeout_abort: assert property (
        tif.expired |=> rp_abort && err[ERR_TMO_BIT] ##1 !rp_abort)
        else $error("timeout did not abort and flag");

    a_guard_readback: assert property (
        reg_rd && reg_addr == ADDR_GUARD && !reg_wr |=> reg_rdata == $past(guard))
        else $error("guard readback mismatch");

    a_row_prog_flag: assert property (
        s_guarded_row_prog |=> op_deny && !op_grant && err[ERR_WR_BIT])
        else $error("guarded row program not flagged");

    a_grant_unguarded: assert property (
        op_req && kind != OP_MASS_ERASE && !blk_guarded |=> op_grant && !op_deny)
        else $error("unguarded block access refused");

    a_mass_erase_free: assert property (
        s_mass_try_free |=> op_grant && !op_deny)
        else $error("mass erase refused with no guard bit set");

    // Upper half of the address space does not exist on the small part
    a_small_ignores_top: assert property (
        small_dev && op_req && kind == OP_WRITE && !op_info && op_addr[BLK_MSB] |=> op_grant)
        else $error("missing upper block still guarded");

    a_relock_wins: assert property (
        key_relock |=> locked)
        else $error("relock request did not lock");

    a_unlock_needs_key: assert property (
        $fell(locked) |-> $past(key_unlock))
        else $error("guard register unlocked without key");

    a_guard_stable: assert property (
        !wr_guard |=> $stable(guard))
        else $error("guard register changed without a write");

    a_done_flag_sets: assert property (
        op_done |=> done_flag)
        else $error("done flag not set on completion");

    a_done_irq_follows: assert property (
        done_ie && done_flag |=> irq_done)
        else $error("done interrupt not raised");

    a_err_irq_gated: assert property (
        !err_ie |=> !irq_err)
        else $error("error interrupt raised while disabled");
endmodule

//--- testbench/fbp_flash_eng.sv
// Flash engine model that asks the guard for permission and finishes jobs
`timescale 1ns/1ps
module fbp_flash_eng
    import fbp_pkg::*;
(
    input  wire logic               sys_clk,
    input  wire logic               op_grant,
    input  wire logic               op_deny,
    output logic                    op_req,
    output logic [1:0]              op_kind,
    output logic [FADDR_W-1:0]      op_addr,
    output logic                    op_info,
    output logic                    op_done,
    output logic                    fctl_tick
);
    logic run_tick = 1'b0;
    logic auto_done = 1'b1;
    initial begin
        op_req = 1'b0;
        op_kind = 2'b00;
        op_addr = '0;
        op_info = 1'b0;
        op_done = 1'b0;
    end
    // Ticks only on demand, so a running watchdog does not count otherwise
    always @(posedge sys_clk) begin
        fctl_tick <= run_tick;
    end
    task automatic request(input logic [1:0] k, input logic [FADDR_W-1:0] a,
                           input logic inf, output logic [1:0] resp);
        @(posedge sys_clk);
        op_req <= 1'b1;
        op_kind <= k;
        op_addr <= a;
        op_info <= inf;
        @(posedge sys_clk);
        op_req <= 1'b0;
        // Released qualifiers must not keep showing the old value
        op_addr <= ~a;
        op_info <= ~inf;
        #1;
        resp = {op_grant, op_deny};
        if (resp === 2'b10 && auto_done && k != OP_WRITE) begin
            repeat (3) @(posedge sys_clk);
            op_done <= 1'b1;
            @(posedge sys_clk);
            op_done <= 1'b0;
        end
    endtask
endmodule

//--- testbench/tb_top.sv
// Self-checking bench for the flash block guard
`timescale 1ns/1ps
module tb_top;
    import fbp_pkg::*;
    logic               sys_clk = 1'b0;
    logic               rst_n = 1'b0;
    logic [7:0]         reg_addr = 8'h00;
    logic [7:0]         reg_wdata = 8'h00;
    logic               reg_wr = 1'b0;
    logic               reg_rd = 1'b0;
    logic               key_unlock = 1'b0;
    logic               key_relock = 1'b0;
    logic               small_dev = 1'b0;
    logic [7:0]         reg_rdata;
    logic [1:0]         op_kind;
    logic [FADDR_W-1:0] op_addr;
    logic               op_req, op_info, op_done, fctl_tick, op_grant, op_deny;
    logic               rp_abort, locked, irq_err, irq_done;
    int                 bad_count = 0;
    int                 checked = 0;
    int                 cycles = 0;

    always #10 sys_clk = ~sys_clk;

    fbp_guard u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .key_unlock(key_unlock), .key_relock(key_relock), .small_dev(small_dev),
        .op_req(op_req), .op_kind(op_kind), .op_addr(op_addr), .op_info(op_info),
        .op_done(op_done), .fctl_tick(fctl_tick), .op_grant(op_grant), .op_deny(op_deny),
        .rp_abort(rp_abort), .locked(locked), .irq_err(irq_err), .irq_done(irq_done));

    fbp_flash_eng u_eng (.sys_clk(sys_clk), .op_grant(op_grant), .op_deny(op_deny),
        .op_req(op_req), .op_kind(op_kind), .op_addr(op_addr), .op_info(op_info),
        .op_done(op_done), .fctl_tick(fctl_tick));

    task test_done;
        $display("Comparisons %0d, mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Hang guard; the watchdog scenario alone needs about 2500 cycles
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            test_done;
        end
    end

    task chk(input logic [7:0] g, input logic [7:0] e);
        checked++;
        if (g !== e) begin
            $display("Error t=%0t got %h exp %h", $time, g, e);
            bad_count++;
        end
    endtask

    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, e);
    endtask

    task key(input logic un);
        @(posedge sys_clk);
        if (un) key_unlock <= 1'b1;
        else key_relock <= 1'b1;
        @(posedge sys_clk);
        key_unlock <= 1'b0;
        key_relock <= 1'b0;
        #1;
    endtask

    task op_chk(input logic [1:0] k, input logic [FADDR_W-1:0] a, input logic inf,
                input logic [1:0] e);
        logic [1:0] resp;
        u_eng.request(k, a, inf, resp);
        chk({6'h00, resp}, {6'h00, e});
    endtask

    // Line is read after the wait, not when the task is called
    task flag_chk(input logic use_done, input logic e);
        repeat (2) @(posedge sys_clk);
        #1;
        chk({7'h00, (use_done ? irq_done : irq_err)}, {7'h00, e});
    endtask

    task t_reset;
        rd_chk(ADDR_GUARD, 8'hFF);
        rd_chk(ADDR_IRQ, 8'h00);
        chk({7'h00, locked}, 8'h01);
    endtask

    task t_lock;
        wr(ADDR_GUARD, 8'h00);
        rd_chk(ADDR_GUARD, 8'hFF);
        key(1'b1);
        chk({7'h00, locked}, 8'h00);
        wr(ADDR_GUARD, 8'h5A);
        rd_chk(ADDR_GUARD, 8'h5A);
        wr(8'h10, 8'h33);
        rd_chk(8'h10, 8'h00);
        key(1'b0);
        wr(ADDR_GUARD, 8'h00);
        rd_chk(ADDR_GUARD, 8'hFF);
        key(1'b1);
    endtask

    // Each guard bit alone, probed at the low edge of even blocks and the high edge of odd ones
    task t_blocks;
        for (int n = 0; n < 8; n++) begin
            wr(ADDR_GUARD, 8'(1 << n));
            for (int m = 0; m < 8; m++) begin
                op_chk(OP_WRITE, 17'(m * 17'h04000 + (m % 2) * 17'h03FFF), 1'b0,
                       (m == n) ? 2'b01 : 2'b10);
            end
        end
        rd_chk(ADDR_IRQ, 8'h04);
        rd_chk(ADDR_IRQ, 8'h00);
    endtask

    task t_erase;
        wr(ADDR_GUARD, 8'h01);
        op_chk(OP_PAGE_ERASE, 17'h00100, 1'b1, 2'b10);
        op_chk(OP_PAGE_ERASE, 17'h00100, 1'b0, 2'b01);
        op_chk(OP_PAGE_ERASE, 17'h04100, 1'b0, 2'b10);
        op_chk(OP_MASS_ERASE, 17'h00000, 1'b0, 2'b01);
        rd_chk(ADDR_IRQ, 8'h23);
        wr(ADDR_GUARD, 8'h00);
        op_chk(OP_MASS_ERASE, 17'h00000, 1'b0, 2'b10);
        rd_chk(ADDR_IRQ, 8'h20);
    endtask

    task t_small;
        @(posedge sys_clk);
        small_dev <= 1'b1;
        wr(ADDR_GUARD, 8'hF0);
        op_chk(OP_MASS_ERASE, 17'h00000, 1'b0, 2'b10);
        op_chk(OP_WRITE, 17'h1C000, 1'b0, 2'b10);
        rd_chk(ADDR_GUARD, 8'hF0);
        @(posedge sys_clk);
        small_dev <= 1'b0;
        op_chk(OP_MASS_ERASE, 17'h00000, 1'b0, 2'b01);
        rd_chk(ADDR_IRQ, 8'h21);
    endtask

    task t_irq;
        wr(ADDR_IRQ, 8'h40);
        op_chk(OP_WRITE, 17'h1C000, 1'b0, 2'b01);
        flag_chk(1'b0, 1'b1);
        rd_chk(ADDR_IRQ, 8'h44);
        flag_chk(1'b0, 1'b0);
        wr(ADDR_IRQ, 8'h00);
        op_chk(OP_WRITE, 17'h1C000, 1'b0, 2'b01);
        flag_chk(1'b0, 1'b0);
        rd_chk(ADDR_IRQ, 8'h04);
        op_chk(OP_PAGE_ERASE, 17'h00000, 1'b0, 2'b10);
        flag_chk(1'b1, 1'b0);
        wr(ADDR_IRQ, 8'h80);
        flag_chk(1'b1, 1'b1);
        rd_chk(ADDR_IRQ, 8'hA0);
        flag_chk(1'b1, 1'b0);
    endtask

    // Row program: refused in a guarded block, completes in a free one
    task t_rowprog;
        op_chk(OP_ROW_PROG, 17'h1C000, 1'b0, 2'b01);
        op_chk(OP_ROW_PROG, 17'h00000, 1'b0, 2'b10);
        rd_chk(ADDR_IRQ, 8'hA4);
    endtask

    // Ticks every cycle so the 2432-tick limit is reached quickly
    task t_timeout;
        int n;
        wr(ADDR_GUARD, 8'h00);
        wr(ADDR_IRQ, 8'h40);
        u_eng.auto_done = 1'b0;
        @(posedge sys_clk);
        u_eng.run_tick <= 1'b1;
        op_chk(OP_ROW_PROG, 17'h08000, 1'b0, 2'b10);
        n = 0;
        while (rp_abort !== 1'b1 && n < 3000) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        chk({7'h00, n >= 2429 && n <= 2435}, 8'h01);
        u_eng.run_tick <= 1'b0;
        flag_chk(1'b0, 1'b1);
        rd_chk(ADDR_IRQ, 8'h48);
    endtask

    initial begin
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_reset;
        t_lock;
        t_blocks;
        t_erase;
        t_small;
        t_irq;
        t_rowprog;
        t_timeout;
        test_done;
    end
endmodule
